// *** src/osr_pkg.sv ***
`default_nettype none
package osr_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam logic [15:0] OPTION_PHYS_ADDR = 16'h7fff;
    localparam logic [15:0] OPTION_ALIAS_ADDR = 16'hffff;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] SECURED_READ_VALUE = 8'hff;
    localparam logic [7:0] SP_RESET = 8'h6f;
    localparam logic [7:0] IDLE_CTRL_RESET = 8'h40;
    localparam logic [7:0] SERIAL_CTRL_RESET = 8'h02;
    localparam logic [7:0] PROG_TIMING_10MHZ = 8'h10;
    localparam logic [7:0] BYTE_CLEAR = 8'h00;
    localparam int unsigned OPT_WDOG_DIS_BIT = 2;
    localparam int unsigned OPT_HALT_DIS_BIT = 1;
    localparam int unsigned OPT_FLASH_EXEC_BIT = 0;
    localparam int unsigned OPT_SECURE_BIT = 5;
    localparam logic [1:0] WDOG_WINDOW_MAX = 2'h3;
    localparam int unsigned WDOG_WINDOW_CYCLES = 65536;
    localparam int unsigned CLKMON_RELEASE_MIN = 16;
    localparam int unsigned CLKMON_RELEASE_MAX = 32;
    localparam logic [5:0] CLKMON_RELEASE_COUNT = 6'h10;
    typedef enum logic [1:0] {
        FL_READ,
        FL_WRITE,
        FL_PAGE_ERASE,
        FL_MASS_ERASE
    } osr_flash_op_type;
endpackage : osr_pkg
`default_nettype wire

// *** src/osr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module osr_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stageOne;

    // First stage feeds only the second
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stageOne <= '0;
            syncOut <= '0;
        end else begin
            stageOne <= asyncIn;
            syncOut <= stageOne;
        end
    end
endmodule : osr_sync
`default_nettype wire

// *** src/osr_reset_init.sv ***
`timescale 1ns/1ps
`default_nettype none
module osr_reset_init #(
    parameter logic [7:0] OPTION_INIT = 8'h00
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic extResetN,
    input wire logic brownoutReset,
    input wire logic idleTimerTick,
    input wire logic clockSlow,
    input wire logic haltRequest,
    input wire logic userIspMode,
    input wire logic progReq,
    input wire logic [1:0] progOp,
    input wire logic [15:0] progAddr,
    input wire logic [7:0] progWriteData,
    input wire logic [7:0] flashReadData,
    input wire logic [7:0] cpuWriteData,
    input wire logic cpuWriteSerial,
    input wire logic cpuWritePointers,
    output logic coreInReset,
    output logic fetchEnable,
    output logic fetchFromFlash,
    output logic [15:0] programCounter,
    output logic haltActive,
    output logic haltAllowed,
    output logic [7:0] progReadData,
    output logic progAck,
    output logic flashWriteEn,
    output logic flashPageEraseEn,
    output logic flashMassEraseEn,
    output logic [7:0] optionConfigByte,
    output logic watchdogEnabled,
    output logic watchdogPinOut,
    output logic watchdogPinOe,
    output logic watchdogPullup,
    output logic gPinZeroPullup,
    output logic gPinTwoPullup,
    output logic [6:0] portOe,
    output logic portDOut,
    output logic [7:0] procStatusWord,
    output logic [7:0] mainControlReg,
    output logic [7:0] irqControlReg,
    output logic [7:0] timerTwoControl,
    output logic [7:0] timerThreeControl,
    output logic [7:0] fastTimerControl,
    output logic [7:0] idleTimerControl,
    output logic [7:0] wakeEnableReg,
    output logic [7:0] wakeEdgeReg,
    output logic [7:0] stackPointer,
    output logic [7:0] dataSegmentReg,
    output logic [7:0] serialPrescaler,
    output logic [7:0] serialCtrlA,
    output logic [7:0] serialRxCtrl,
    output logic [7:0] serialIrqCtrl,
    output logic [7:0] converterEnableReg,
    output logic [7:0] progAddrLow,
    output logic [7:0] progAddrHigh,
    output logic [7:0] progTimingReg,
    output logic [7:0] serialShiftReg,
    output logic [7:0] memPointerB,
    output logic [7:0] memPointerX,
    output logic [1:0] wdogWindow,
    output logic clockMonitorArmed,
    output logic clockMonitorError
);
    logic [2:0] rawIn;
    logic [2:0] syncIn;
    logic extResetSync;
    logic brownoutSync;
    logic clockSlowSync;
    logic anyReset;
    logic resetSeen;
    logic [7:0] optionByte;
    logic [5:0] cmCount;
    logic secured;
    logic isOptionAddr;
    logic next_flashWriteEn;
    logic next_pageErase;
    logic next_massErase;
    logic [7:0] next_readData;

    assign rawIn = {clockSlow, brownoutReset, ~extResetN};

    // Pins and brownout come from outside this clock
    osr_sync #(
        .WIDTH(3)
    ) inSync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .asyncIn(rawIn),
        .syncOut(syncIn)
    );

    assign extResetSync = syncIn[0];
    assign brownoutSync = syncIn[1];
    assign clockSlowSync = syncIn[2];
    // A pulse shorter than one clock may be missed by the synchroniser
    assign anyReset = extResetSync | brownoutSync;
    assign secured = optionByte[osr_pkg::OPT_SECURE_BIT];

    function automatic logic optAddr(input logic [15:0] addr);
        optAddr = (addr == osr_pkg::OPTION_ALIAS_ADDR) || (addr == osr_pkg::OPTION_PHYS_ADDR);
    endfunction : optAddr

    assign isOptionAddr = optAddr(progAddr);

    // Option byte storage; mass erase returns it to the erased state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            optionByte <= OPTION_INIT;
        end else if (progReq && progOp == osr_pkg::FL_MASS_ERASE) begin
            optionByte <= osr_pkg::BYTE_CLEAR;
        end else if (progReq && progOp == osr_pkg::FL_WRITE && isOptionAddr
                     && (!secured || userIspMode)) begin
            optionByte <= progWriteData;
        end
    end

    // Protection gating of external accesses
    always_comb begin
        next_flashWriteEn = 1'b0;
        next_pageErase = 1'b0;
        next_massErase = 1'b0;
        next_readData = flashReadData;
        if (progReq) begin
            case (progOp)
                osr_pkg::FL_READ: begin
                    if (optAddr(progAddr)) begin
                        next_readData = optionByte;
                    end else if (secured && !userIspMode) begin
                        next_readData = osr_pkg::SECURED_READ_VALUE;
                    end
                end
                osr_pkg::FL_WRITE: begin
                    next_flashWriteEn = !secured || userIspMode;
                end
                osr_pkg::FL_PAGE_ERASE: begin
                    next_pageErase = !secured || userIspMode;
                end
                osr_pkg::FL_MASS_ERASE: begin
                    next_massErase = 1'b1;
                end
                default: begin
                    next_massErase = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            progReadData <= osr_pkg::BYTE_CLEAR;
            progAck <= 1'b0;
            flashWriteEn <= 1'b0;
            flashPageEraseEn <= 1'b0;
            flashMassEraseEn <= 1'b0;
            optionConfigByte <= osr_pkg::BYTE_CLEAR;
        end else begin
            progReadData <= next_readData;
            progAck <= progReq;
            flashWriteEn <= next_flashWriteEn;
            flashPageEraseEn <= next_pageErase;
            flashMassEraseEn <= next_massErase;
            optionConfigByte <= optionByte;
        end
    end

    // Core sequencing and option decode
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            coreInReset <= 1'b1;
            fetchEnable <= 1'b0;
            fetchFromFlash <= 1'b0;
            programCounter <= osr_pkg::PC_RESET;
            haltActive <= 1'b0;
            haltAllowed <= 1'b0;
            watchdogEnabled <= 1'b0;
        end else begin
            coreInReset <= anyReset;
            fetchEnable <= !anyReset;
            fetchFromFlash <= optionByte[osr_pkg::OPT_FLASH_EXEC_BIT];
            haltAllowed <= !optionByte[osr_pkg::OPT_HALT_DIS_BIT];
            watchdogEnabled <= !optionByte[osr_pkg::OPT_WDOG_DIS_BIT];
            if (anyReset) begin
                programCounter <= osr_pkg::PC_RESET;
                haltActive <= 1'b0;
            end else if (haltRequest && !optionByte[osr_pkg::OPT_HALT_DIS_BIT]) begin
                haltActive <= 1'b1;
            end
        end
    end

    // Peripheral control registers held at reset values while reset stands
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            procStatusWord <= osr_pkg::BYTE_CLEAR;
            mainControlReg <= osr_pkg::BYTE_CLEAR;
            irqControlReg <= osr_pkg::BYTE_CLEAR;
            timerTwoControl <= osr_pkg::BYTE_CLEAR;
            timerThreeControl <= osr_pkg::BYTE_CLEAR;
            fastTimerControl <= osr_pkg::BYTE_CLEAR;
            idleTimerControl <= osr_pkg::IDLE_CTRL_RESET;
            wakeEnableReg <= osr_pkg::BYTE_CLEAR;
            wakeEdgeReg <= osr_pkg::BYTE_CLEAR;
            stackPointer <= osr_pkg::SP_RESET;
            dataSegmentReg <= osr_pkg::BYTE_CLEAR;
            serialPrescaler <= osr_pkg::BYTE_CLEAR;
            serialCtrlA <= osr_pkg::SERIAL_CTRL_RESET;
            serialRxCtrl <= osr_pkg::BYTE_CLEAR;
            serialIrqCtrl <= osr_pkg::BYTE_CLEAR;
            converterEnableReg <= osr_pkg::BYTE_CLEAR;
            progAddrLow <= osr_pkg::BYTE_CLEAR;
            progAddrHigh <= osr_pkg::BYTE_CLEAR;
            progTimingReg <= osr_pkg::PROG_TIMING_10MHZ;
        end else if (anyReset) begin
            procStatusWord <= osr_pkg::BYTE_CLEAR;
            mainControlReg <= osr_pkg::BYTE_CLEAR;
            irqControlReg <= osr_pkg::BYTE_CLEAR;
            timerTwoControl <= osr_pkg::BYTE_CLEAR;
            timerThreeControl <= osr_pkg::BYTE_CLEAR;
            fastTimerControl <= osr_pkg::BYTE_CLEAR;
            idleTimerControl <= osr_pkg::IDLE_CTRL_RESET;
            wakeEnableReg <= osr_pkg::BYTE_CLEAR;
            wakeEdgeReg <= osr_pkg::BYTE_CLEAR;
            stackPointer <= osr_pkg::SP_RESET;
            dataSegmentReg <= osr_pkg::BYTE_CLEAR;
            serialPrescaler <= osr_pkg::BYTE_CLEAR;
            serialCtrlA <= osr_pkg::SERIAL_CTRL_RESET;
            serialRxCtrl <= osr_pkg::BYTE_CLEAR;
            serialIrqCtrl <= osr_pkg::BYTE_CLEAR;
            converterEnableReg <= osr_pkg::BYTE_CLEAR;
            progAddrLow <= osr_pkg::BYTE_CLEAR;
            progAddrHigh <= osr_pkg::BYTE_CLEAR;
            progTimingReg <= osr_pkg::PROG_TIMING_10MHZ;
        end
    end

    // Warm reset never touches these; only the core may load them
    always_ff @(posedge sys_clk) begin
        if (!anyReset && cpuWriteSerial) begin
            serialShiftReg <= cpuWriteData;
        end
        if (!anyReset && cpuWritePointers) begin
            memPointerB <= cpuWriteData;
            memPointerX <= cpuWriteData;
        end
    end

    // Ports: all inputs in reset, port D high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            portOe <= 7'h00;
            portDOut <= 1'b1;
            gPinZeroPullup <= 1'b1;
            gPinTwoPullup <= 1'b1;
            watchdogPullup <= 1'b0;
        end else begin
            if (anyReset) begin
                portOe <= 7'h00;
                portDOut <= 1'b1;
            end
            gPinZeroPullup <= anyReset;
            gPinTwoPullup <= anyReset;
            watchdogPullup <= !optionByte[osr_pkg::OPT_WDOG_DIS_BIT];
        end
    end

    // Watchdog window reset to max; clock monitor inhibited in reset, armed at release unless the watchdog-disable option bit is set
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdogWindow <= osr_pkg::WDOG_WINDOW_MAX;
            clockMonitorArmed <= 1'b0;
            clockMonitorError <= 1'b0;
            cmCount <= 6'h00;
            resetSeen <= 1'b1;
        end else begin
            resetSeen <= anyReset;
            if (anyReset) begin
                wdogWindow <= osr_pkg::WDOG_WINDOW_MAX;
                clockMonitorArmed <= 1'b0;
                clockMonitorError <= 1'b0;
                cmCount <= 6'h00;
            end else begin
                clockMonitorArmed <= !optionByte[osr_pkg::OPT_WDOG_DIS_BIT];
                if (resetSeen && clockSlowSync && !optionByte[osr_pkg::OPT_WDOG_DIS_BIT]) begin
                    clockMonitorError <= 1'b1;
                    cmCount <= 6'h00;
                end else if (clockMonitorError) begin
                    // Counts idle-timer ticks once the clock is up to speed
                    if (clockSlowSync) begin
                        cmCount <= 6'h00;
                    end else if (idleTimerTick) begin
                        if (cmCount == osr_pkg::CLKMON_RELEASE_COUNT - 6'h01) begin
                            clockMonitorError <= 1'b0;
                        end
                        cmCount <= cmCount + 6'h01;
                    end
                end
            end
        end
    end

    // Watchdog pin: driven only when the watchdog owns it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            watchdogPinOe <= 1'b0;
            watchdogPinOut <= 1'b1;
        end else begin
            watchdogPinOe <= !optionByte[osr_pkg::OPT_WDOG_DIS_BIT] && clockMonitorError;
            watchdogPinOut <= !clockMonitorError;
        end
    end
endmodule : osr_reset_init
`default_nettype wire

// *** bench/osr_reset_init_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module osr_reset_init_sva (
    input wire logic sys_clk, rstn, extResetN, brownoutReset, progReq, userIspMode,
    input wire logic [1:0] progOp,
    input wire logic [15:0] progAddr, programCounter,
    input wire logic haltActive, haltAllowed, progAck, flashWriteEn, flashPageEraseEn,
    input wire logic flashMassEraseEn, coreInReset, fetchEnable, portDOut, gPinZeroPullup,
    input wire logic gPinTwoPullup, clockMonitorError, watchdogPinOe, watchdogPinOut,
    input wire logic [7:0] progReadData, optionConfigByte, stackPointer, idleTimerControl,
    input wire logic [7:0] serialCtrlA,
    input wire logic [6:0] portOe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire logic isOpt = (progAddr == osr_pkg::OPTION_PHYS_ADDR)
        || (progAddr == osr_pkg::OPTION_ALIAS_ADDR);
    // User ISP lifts the lock, so it is folded in once here
    wire logic locked = optionConfigByte[osr_pkg::OPT_SECURE_BIT] && !userIspMode;
    wire logic isRd = progReq && (progOp == osr_pkg::FL_READ);
    property p_secRead;
        isRd && locked && !isOpt |=> progAck && progReadData == osr_pkg::SECURED_READ_VALUE;
    endproperty
    a_secRead: assert property (p_secRead) else $error("secured read not ff");
    property p_optRead;
        isRd && isOpt |=> progReadData == $past(optionConfigByte);
    endproperty
    a_optRead: assert property (p_optRead) else $error("option read wrong");
    property p_secWrite;
        progReq && progOp inside {osr_pkg::FL_WRITE, osr_pkg::FL_PAGE_ERASE} && locked
        |=> !flashWriteEn && !flashPageEraseEn;
    endproperty
    a_secWrite: assert property (p_secWrite) else $error("secured write passed");
    property p_mass;
        progReq && progOp == osr_pkg::FL_MASS_ERASE
        |=> flashMassEraseEn ##[0:1] optionConfigByte == osr_pkg::BYTE_CLEAR;
    endproperty
    a_mass: assert property (p_mass) else $error("mass erase failed");
    property p_coreRst;
        coreInReset |-> programCounter == osr_pkg::PC_RESET && !fetchEnable
            && stackPointer == osr_pkg::SP_RESET && serialCtrlA == osr_pkg::SERIAL_CTRL_RESET
            && idleTimerControl == osr_pkg::IDLE_CTRL_RESET;
    endproperty
    a_coreRst: assert property (p_coreRst) else $error("core reset value");
    property p_portRst;
        coreInReset |-> portOe == 7'h00 && portDOut && gPinZeroPullup && gPinTwoPullup;
    endproperty
    a_portRst: assert property (p_portRst) else $error("port reset state");
    property p_extRst;
        $fell(extResetN) |-> ##[1:4] (coreInReset && !haltActive);
    endproperty
    a_extRst: assert property (p_extRst) else $error("external reset ignored");
    property p_fetch;
        $rose(fetchEnable) |-> $past(extResetN, 2) && !$past(brownoutReset, 2);
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch during reset");
    property p_halt;
        $rose(haltActive) |-> haltAllowed;
    endproperty
    a_halt: assert property (p_halt) else $error("halt entered while barred");
    property p_cmPin;
        clockMonitorError && $past(clockMonitorError) |-> watchdogPinOe && !watchdogPinOut;
    endproperty
    a_cmPin: assert property (p_cmPin) else $error("monitor pin not low");
    c_mass: cover property (progReq && progOp == osr_pkg::FL_MASS_ERASE);
    c_cm: cover property ($rose(clockMonitorError));
    c_halt: cover property ($rose(haltActive));
endmodule : osr_reset_init_sva
`default_nettype wire

// *** bench/osr_far_side.sv ***
`timescale 1ns/1ps
`default_nettype none
module osr_far_side #(
    parameter int unsigned INSTR_CYCLES = 4
) (
    input wire logic sys_clk,
    input wire logic [15:0] progAddr,
    output logic [7:0] flashReadData,
    output logic extResetN
);
    // Array holds an address pattern; writes are not stored, the bench checks enables
    assign flashReadData = progAddr[7:0] ^ 8'h3c;
    initial extResetN = 1'b1;
    task automatic pulse_reset(input int unsigned cycles);
        int unsigned n;
        n = (cycles < INSTR_CYCLES) ? INSTR_CYCLES : cycles;
        @(negedge sys_clk);
        extResetN = 1'b0;
        repeat (n) @(negedge sys_clk);
        extResetN = 1'b1;
    endtask : pulse_reset
endmodule : osr_far_side
`default_nettype wire

// *** bench/option_security_reset_init_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module option_security_reset_init_tb;
    logic sys_clk = 1'b0, rstn = 1'b0, brownoutReset = 1'b0, idleTimerTick = 1'b0;
    logic clockSlow = 1'b0, haltRequest = 1'b0, userIspMode = 1'b0, progReq = 1'b0;
    logic cpuWriteSerial = 1'b0, cpuWritePointers = 1'b0;
    logic [1:0] progOp = 2'h0;
    logic [15:0] progAddr = 16'h0000;
    logic [7:0] progWriteData = 8'h00, cpuWriteData = 8'h00;
    logic extResetN;
    logic [7:0] flashReadData;
    logic coreInReset, fetchEnable, fetchFromFlash, haltActive, haltAllowed, progAck;
    logic flashWriteEn, flashPageEraseEn, flashMassEraseEn, watchdogEnabled, watchdogPinOut;
    logic watchdogPinOe, watchdogPullup, gPinZeroPullup, gPinTwoPullup, portDOut;
    logic clockMonitorArmed, clockMonitorError;
    logic [15:0] programCounter;
    logic [6:0] portOe;
    logic [1:0] wdogWindow;
    logic [7:0] progReadData, optionConfigByte, procStatusWord, mainControlReg, irqControlReg;
    logic [7:0] timerTwoControl, timerThreeControl, fastTimerControl, idleTimerControl;
    logic [7:0] wakeEnableReg, wakeEdgeReg, stackPointer, dataSegmentReg, serialPrescaler;
    logic [7:0] serialCtrlA, serialRxCtrl, serialIrqCtrl, converterEnableReg, progAddrLow;
    logic [7:0] progAddrHigh, progTimingReg, serialShiftReg, memPointerB, memPointerX;
    logic ack, wen, pen, men;
    logic [7:0] rd;
    int errorCnt = 0;
    int cmpCount = 0;
    always #2 sys_clk = ~sys_clk;
    osr_reset_init #(.OPTION_INIT(8'h01)) dut (.*);
    osr_far_side u_far (.sys_clk(sys_clk), .progAddr(progAddr),
        .flashReadData(flashReadData), .extResetN(extResetN));
    task automatic reportAndStop();
        $display("errors=%0d compares=%0d", errorCnt, cmpCount);
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : reportAndStop
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic waitFetch();
        int i;
        for (i = 0; i < 20 && fetchEnable !== 1'b1; i++) @(negedge sys_clk);
        if (fetchEnable !== 1'b1) begin
            errorCnt++;
            reportAndStop();
        end
    endtask : waitFetch
    task automatic prog(input logic [1:0] op, input logic [15:0] addr, input logic [7:0] wd);
        progOp = op;
        progAddr = addr;
        progWriteData = wd;
        progReq = 1'b1;
        @(negedge sys_clk);
        // Answer stands one cycle only, so it is caught before the next edge
        {ack, rd, wen, pen, men} = {progAck, progReadData, flashWriteEn, flashPageEraseEn,
            flashMassEraseEn};
        progReq = 1'b0;
        @(negedge sys_clk);
    endtask : prog
    task automatic t_reset_vals();
        chk(64'({coreInReset, fetchEnable, programCounter}), 64'({2'h2, osr_pkg::PC_RESET}));
        chk(64'({procStatusWord, mainControlReg, irqControlReg}), 64'h0);
        chk(64'({timerTwoControl, timerThreeControl, fastTimerControl, idleTimerControl}),
            64'({24'h0, osr_pkg::IDLE_CTRL_RESET}));
        chk(64'({wakeEnableReg, wakeEdgeReg, stackPointer, dataSegmentReg}),
            64'({16'h0, osr_pkg::SP_RESET, 8'h00}));
        chk(64'({serialPrescaler, serialCtrlA, serialRxCtrl, serialIrqCtrl}),
            64'({8'h00, osr_pkg::SERIAL_CTRL_RESET, 16'h0}));
        chk(64'({converterEnableReg, progAddrLow, progAddrHigh, progTimingReg}),
            64'({24'h0, osr_pkg::PROG_TIMING_10MHZ}));
        chk(64'({portOe, portDOut, gPinZeroPullup, gPinTwoPullup}), 64'h7);
        chk(64'({wdogWindow, watchdogPinOe, watchdogPinOut}),
            64'({osr_pkg::WDOG_WINDOW_MAX, 2'h1}));
    endtask : t_reset_vals
    task automatic t_halt_warm();
        haltRequest = 1'b1;
        @(negedge sys_clk);
        haltRequest = 1'b0;
        cpuWriteData = 8'ha5;
        {cpuWriteSerial, cpuWritePointers} = 2'h3;
        repeat (2) @(negedge sys_clk);
        {cpuWriteSerial, cpuWritePointers} = 2'h0;
        chk(64'(haltActive), 64'h1);
        u_far.pulse_reset(8);
        chk(64'(haltActive), 64'h0);
        waitFetch();
        chk(64'({serialShiftReg, memPointerB, memPointerX}), 64'ha5a5a5);
        brownoutReset = 1'b1;
        repeat (6) @(negedge sys_clk);
        t_reset_vals();
        brownoutReset = 1'b0;
        waitFetch();
    endtask : t_halt_warm
    task automatic t_secure();
        prog(osr_pkg::FL_READ, 16'h0123, 8'h00);
        chk(64'({ack, rd}), 64'h11f);
        prog(osr_pkg::FL_PAGE_ERASE, 16'h7f80, 8'h00);
        chk(64'(pen), 64'h1);
        prog(osr_pkg::FL_WRITE, 16'h7fff, 8'h27);
        @(negedge sys_clk);
        chk(64'(optionConfigByte), 64'h27);
        u_far.pulse_reset(8);
        waitFetch();
        chk(64'({fetchFromFlash, haltAllowed, watchdogEnabled, watchdogPinOe}), 64'h8);
        haltRequest = 1'b1;
        @(negedge sys_clk);
        haltRequest = 1'b0;
        @(negedge sys_clk);
        chk(64'(haltActive), 64'h0);
        prog(osr_pkg::FL_READ, 16'h0123, 8'h00);
        chk(64'({ack, rd}), 64'h1ff);
        prog(osr_pkg::FL_READ, 16'hffff, 8'h00);
        chk(64'(rd), 64'h27);
        prog(osr_pkg::FL_WRITE, 16'h0100, 8'h55);
        chk(64'(wen), 64'h0);
        prog(osr_pkg::FL_PAGE_ERASE, 16'h7f80, 8'h00);
        chk(64'(pen), 64'h0);
        prog(osr_pkg::FL_WRITE, 16'hffff, 8'h00);
        chk(64'(optionConfigByte), 64'h27);
        userIspMode = 1'b1;
        prog(osr_pkg::FL_READ, 16'h0123, 8'h00);
        chk(64'(rd), 64'h1f);
        prog(osr_pkg::FL_WRITE, 16'h0100, 8'h55);
        chk(64'(wen), 64'h1);
        userIspMode = 1'b0;
    endtask : t_secure
    task automatic t_mass_monitor();
        prog(osr_pkg::FL_MASS_ERASE, 16'h0000, 8'h00);
        chk(64'({men, optionConfigByte}), 64'h100);
        clockSlow = 1'b1;
        u_far.pulse_reset(8);
        waitFetch();
        repeat (4) @(negedge sys_clk);
        chk(64'({fetchFromFlash, watchdogEnabled}), 64'h1);
        chk(64'({clockMonitorError, watchdogPinOe, watchdogPinOut}), 64'h6);
        clockSlow = 1'b0;
        repeat (3) @(negedge sys_clk);
        for (int i = 0; i < 32; i++) begin
            idleTimerTick = ~idleTimerTick;
            @(negedge sys_clk);
            if (i == 29) chk(64'(clockMonitorError), 64'h1);
        end
        repeat (3) @(negedge sys_clk);
        chk(64'({clockMonitorError, watchdogPinOut}), 64'h1);
    endtask : t_mass_monitor
    initial begin
        repeat (10) @(negedge sys_clk);
        t_reset_vals();
        rstn = 1'b1;
        waitFetch();
        chk(64'({fetchFromFlash, haltAllowed, watchdogEnabled, clockMonitorArmed,
            watchdogPullup}), 64'h1f);
        t_halt_warm();
        t_secure();
        t_mass_monitor();
        reportAndStop();
    end
endmodule : option_security_reset_init_tb
bind osr_reset_init osr_reset_init_sva u_sva (.*);
`default_nettype wire
